//--- include/ssm_pkg.sv
package ssm_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG2 = 8'h04;
  localparam logic [7:0] OFS_CONTROL_WORD_ONE = 8'h08;
  localparam logic [7:0] OFS_UPPER = 8'h0c;
  localparam logic [7:0] OFS_LOWER = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_MSG = 8'h18;
  localparam logic [7:0] OFS_CODE_BASE = 8'h20;
  localparam logic [7:0] OFS_CODE_LAST = 8'h3c;

  // Field positions.
  localparam int CTRL_ESP_BIT = 0;
  localparam int CTRL_PW_EN_BIT = 1;
  localparam int CTRL_TYPE_LSB = 2;
  localparam int CTRL_REV_LSB = 6;
  localparam int CFG2_TEMP_LSB = 7;
  localparam int CFG2_UV_LSB = 12;
  localparam int CFG2_OV_LSB = 14;
  localparam int CONTROL_WORD_ONE_SBE_BIT = 10;
  localparam int CONTROL_WORD_ONE_DIAG_BIT = 14;

  // Reset values.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] CFG2_RST = 16'h0000;
  localparam logic [15:0] CONTROL_WORD_ONE_RST = 16'h0000;
  localparam logic [11:0] UPPER_RST = 12'hfff;
  localparam logic [11:0] LOWER_RST = 12'h000;
  localparam logic [11:0] CODE_RST = 12'h000;

  // Schedule and framing.
  localparam logic [4:0] SLOT_LAST = 5'h11;
  localparam logic [4:0] FRAME_LAST = 5'h11;
  localparam logic [4:0] CODE_SLOT0 = 5'h0a;
  localparam logic [4:0] SYNC_FRAMES = 5'h06;

  // Message identifiers.
  localparam logic [7:0] ID_DIAG = 8'h01;
  localparam logic [7:0] ID_TEMP = 8'h23;
  localparam logic [7:0] ID_SUPPLY = 8'h1c;
  localparam logic [7:0] ID_TYPE = 8'h03;
  localparam logic [7:0] ID_SENSOR = 8'h29;
  localparam logic [7:0] ID_MFR = 8'h05;
  localparam logic [7:0] ID_REV = 8'h06;
  localparam logic [7:0] ID_CODE1 = 8'h90;

  // Diagnostic status codes and the supply code limit.
  localparam logic [11:0] DC_OK = 12'h000;
  localparam logic [11:0] DC_UPPER_RANGE_LIMIT = 12'h001;
  localparam logic [11:0] DC_LOWER_RANGE_LIMIT = 12'h002;
  localparam logic [11:0] DC_UNDERVOLT = 12'h020;
  localparam logic [11:0] DC_OVERVOLT = 12'h021;
  localparam logic [11:0] DC_OVERTEMP = 12'h022;
  localparam logic [11:0] DC_SBE = 12'h023;
  localparam logic [11:0] DC_SAFETY_BASE = 12'h800;
  localparam logic [11:0] SUPPLY_LIMIT = 12'h200;

  typedef enum logic [0:0] {SSM_IDLE, SSM_RUN} ssm_state_t;

endpackage

//--- include/ssm_mem_if.sv
interface ssm_mem_if;
  logic wr_en;
  logic [2:0] wr_addr;
  logic [11:0] wr_data;
  logic [2:0] rd_addr_a;
  logic [11:0] rd_data_a;
  logic [2:0] rd_addr_b;
  logic [11:0] rd_data_b;

  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr_a, input rd_addr_b,
    output rd_data_a, output rd_data_b);
  modport user (output wr_en, output wr_addr, output wr_data, output rd_addr_a, output rd_addr_b,
    input rd_data_a, input rd_data_b);
endinterface

//--- rtl/ssm_code_mem.sv
module ssm_code_mem
  import ssm_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Storage port.
  ssm_mem_if.mem port
);

  typedef struct packed {
    logic [7:0][11:0] word;
    logic [11:0] rd_a;
    logic [11:0] rd_b;
  } ssm_mem_st_t;

  ssm_mem_st_t st;
  ssm_mem_st_t next_st;

  always_comb begin
    next_st = st;
    if (port.wr_en) begin
      next_st.word[port.wr_addr] = port.wr_data;
    end
    next_st.rd_a = st.word[port.rd_addr_a];
    next_st.rd_b = st.word[port.rd_addr_b];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{word: {8{CODE_RST}}, rd_a: CODE_RST, rd_b: CODE_RST};
    end else begin
      st <= next_st;
    end
  end

  assign port.rd_data_a = st.rd_a;
  assign port.rd_data_b = st.rd_b;

endmodule

//--- rtl/ssm_top.sv
// Functional notes
// - Slots twelve to eighteen send IDs 91h to 97h with customer codes two to eight.
// - Diagnostic message 01h sends 000h when no fault or warning exists.
// - Diagnostic code 001h when output value exceeds upper range limit.
// - Diagnostic code 002h when output value is below lower range limit.
// - Diagnostic codes 003h-019h and 024h-800h are never sent.
// - Code 020h on undervoltage, 021h on overvoltage, thresholds chosen by config word two.
// - Code 022h when chip temperature exceeds config word two threshold.
// - Code 023h when control word one flags a corrected single-bit error.
// - Codes 801h-FFFh carry the twelve-bit safety error bitmap.
// - Any enabled warning condition also raises status nibble bit 1.
// - Bitmap bit 11 mirrors the diagnostic-mode flag of control word one.
// - Bitmap bits 10 to 6 flag angle, rotation, adder, converter, self-test checks.
// - Bitmap bits 5, 4, 3 flag control/self-test, adjusted angle, conversion checks.
// - Bitmap bits 2, 1, 0 flag division, inverted angle, field conversion checks.
// - Type 0000b-0101b send 051h-056h, 0110b sends 059h, 0111b sends 05Ah.
// - Type 1000b-1011b send 062h, 063h, 064h and 066h.
// - Reserved type settings send 000h.
// - Message 05h always sends the fixed manufacturer code.
// - Revision 00b-11b sends 000h, 002h, 003h, 004h.
// - Supply message 1Ch sends nine-bit values only, never 200h or above.
// - Supply volts equal code plus 33, divided by 58.
// - Each message spans 18 frames on status bits 2 and 3, 8-bit ID, 12-bit data.
// - Slots one to ten fixed, slot eleven sends 90h with customer code one; schedule repeats while enhanced serial is enabled.
module ssm_top
  import ssm_pkg::*;
#(
  // Arbitrary neutral value; replace with the assigned manufacturer code.
  parameter logic [11:0] MFR_CODE = 12'h5a5
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sensor conditions.
  input wire logic [11:0] output_value,
  input wire logic [8:0] supply_code,
  input wire logic [3:0] undervolt_flags,
  input wire logic [3:0] overvolt_flags,
  input wire logic [7:0] chip_temp,
  input wire logic sensor_id_sel,
  input wire logic [10:0] safety_fail,
  // Fast channel frame timing.
  input wire logic frame_start,
  input wire logic [5:0] serial_crc,
  // Slow channel outputs.
  output logic status_bit2,
  output logic status_bit3,
  output logic status_prewarn,
  output logic [7:0] msg_id,
  output logic [11:0] msg_data,
  output logic serial_active
);

  typedef struct packed {
    ssm_state_t state;
    logic [4:0] slot;
    logic [4:0] frame_cnt;
    logic [7:0] msg_id;
    logic [11:0] msg_data;
    logic bit2;
    logic bit3;
    logic prewarn;
    logic [7:0] ctrl;
    logic [15:0] cfg2;
    logic [15:0] control_word_one;
    logic [11:0] upper;
    logic [11:0] lower;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ssm_top_st_t;

  ssm_top_st_t st;
  ssm_top_st_t next_st;
  ssm_mem_if mem_bus ();

  function automatic logic [7:0] slot_id(input logic [4:0] slot);
    case (slot)
      5'd0, 5'd7: slot_id = ID_DIAG;
      5'd1, 5'd8: slot_id = ID_TEMP;
      5'd2, 5'd9: slot_id = ID_SUPPLY;
      5'd3: slot_id = ID_TYPE;
      5'd4: slot_id = ID_SENSOR;
      5'd5: slot_id = ID_MFR;
      5'd6: slot_id = ID_REV;
      default: slot_id = ID_CODE1 + {3'h0, slot - CODE_SLOT0};
    endcase
  endfunction

  function automatic logic [11:0] type_code(input logic [3:0] sel);
    case (sel)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: type_code = 12'h051 + {8'h00, sel};
      4'h6: type_code = 12'h059;
      4'h7: type_code = 12'h05a;
      4'h8: type_code = 12'h062;
      4'h9: type_code = 12'h063;
      4'ha: type_code = 12'h064;
      4'hb: type_code = 12'h066;
      default: type_code = 12'h000;
    endcase
  endfunction

  function automatic logic [11:0] rev_code(input logic [1:0] sel);
    case (sel)
      2'b00: rev_code = 12'h000;
      2'b01: rev_code = 12'h002;
      2'b10: rev_code = 12'h003;
      default: rev_code = 12'h004;
    endcase
  endfunction

  // Bits for one frame: {bit3, bit2}. Frames 1-6 carry the sync pattern and CRC, then
  // the data runs MSB first on bit 2 while bit 3 carries the ID nibbles between zeros.
  function automatic logic [1:0] frame_bits(input logic [4:0] cnt, input logic [7:0] id,
                                            input logic [11:0] data, input logic [5:0] crc);
    logic b3;
    logic b2;
    b3 = 1'b0;
    b2 = 1'b0;
    if (cnt < SYNC_FRAMES) begin
      b3 = 1'b1;
      b2 = crc[3'd5 - cnt[2:0]];
    end else begin
      b2 = data[4'd11 - 4'(cnt - SYNC_FRAMES)];
      if (cnt >= 5'd8 && cnt <= 5'd11) begin
        b3 = id[3'd7 - 3'(cnt - 5'd8)];
      end else if (cnt >= 5'd13 && cnt <= 5'd16) begin
        b3 = id[3'd3 - 3'(cnt - 5'd13)];
      end
    end
    frame_bits = {b3, b2};
  endfunction

  logic [11:0] safety_bitmap;
  logic cond_high;
  logic cond_low;
  logic cond_uv;
  logic cond_ov;
  logic cond_temp;
  logic cond_sbe;
  logic safety_report;
  logic [11:0] diag_code;
  logic [4:0] slot_next;
  logic [11:0] slot_data;
  logic apb_done;
  logic code_hit;

  // Failing checks are active high; bit 11 is the diagnostic-mode flag.
  assign safety_bitmap = {st.control_word_one[CONTROL_WORD_ONE_DIAG_BIT], safety_fail};
  assign cond_high = output_value > st.upper;
  assign cond_low = output_value < st.lower;
  assign cond_uv = undervolt_flags[st.cfg2[CFG2_UV_LSB +: 2]];
  assign cond_ov = overvolt_flags[st.cfg2[CFG2_OV_LSB +: 2]];
  // The five-bit threshold covers the upper bits of the temperature reading.
  assign cond_temp = chip_temp[7:3] > st.cfg2[CFG2_TEMP_LSB +: 5];
  assign cond_sbe = st.control_word_one[CONTROL_WORD_ONE_SBE_BIT];
  // A bitmap is only reported with bit 11 set and a failing check, so 800h never leaves.
  assign safety_report = safety_bitmap[11] && (safety_bitmap[10:0] != 11'h000);

  always_comb begin
    if (safety_report) begin
      diag_code = safety_bitmap;
    end else if (cond_high) begin
      diag_code = DC_UPPER_RANGE_LIMIT;
    end else if (cond_low) begin
      diag_code = DC_LOWER_RANGE_LIMIT;
    end else if (cond_uv) begin
      diag_code = DC_UNDERVOLT;
    end else if (cond_ov) begin
      diag_code = DC_OVERVOLT;
    end else if (cond_temp) begin
      diag_code = DC_OVERTEMP;
    end else if (cond_sbe) begin
      diag_code = DC_SBE;
    end else begin
      diag_code = DC_OK;
    end
  end

  assign slot_next = (st.slot == SLOT_LAST) ? 5'h00 : st.slot + 5'h01;

  // Data for the slot about to be captured; customer codes were prefetched one cycle ahead.
  always_comb begin
    case (slot_id(slot_next))
      ID_DIAG: slot_data = diag_code;
      ID_TEMP: slot_data = {4'h0, chip_temp};
      ID_SUPPLY: slot_data = {3'h0, supply_code};
      ID_TYPE: slot_data = type_code(st.ctrl[CTRL_TYPE_LSB +: 4]);
      ID_SENSOR: slot_data = {12{sensor_id_sel}};
      ID_MFR: slot_data = MFR_CODE;
      ID_REV: slot_data = rev_code(st.ctrl[CTRL_REV_LSB +: 2]);
      default: slot_data = mem_bus.rd_data_b;
    endcase
  end

  assign apb_done = psel && penable && st.pready;
  assign code_hit = paddr >= OFS_CODE_BASE && paddr <= OFS_CODE_LAST && paddr[1:0] == 2'b00;
  assign mem_bus.wr_en = apb_done && pwrite && code_hit;
  assign mem_bus.wr_addr = paddr[4:2];
  assign mem_bus.wr_data = pwdata[11:0];
  assign mem_bus.rd_addr_a = paddr[4:2];
  assign mem_bus.rd_addr_b = 3'(slot_next - CODE_SLOT0);

  ssm_code_mem u_code_mem (
    .pclk(pclk),
    .presetn(presetn),
    .port(mem_bus.mem)
  );

  always_comb begin
    next_st = st;
    // One wait state gives the customer code memory time to answer.
    next_st.pready = psel && penable && !st.pready;
    // The error flag only means something beside pready, so it drops with it.
    next_st.pslverr = 1'b0;
    if (psel && penable && !st.pready) begin
      next_st.prdata = 32'h0000_0000;
      case (paddr)
        OFS_CTRL: next_st.prdata = {24'h00_0000, st.ctrl};
        OFS_CFG2: next_st.prdata = {16'h0000, st.cfg2};
        OFS_CONTROL_WORD_ONE: next_st.prdata = {16'h0000, st.control_word_one};
        OFS_UPPER: next_st.prdata = {20'h0_0000, st.upper};
        OFS_LOWER: next_st.prdata = {20'h0_0000, st.lower};
        OFS_STATUS: next_st.prdata = {19'h0, st.slot, st.frame_cnt, 2'b00, st.state == SSM_RUN};
        OFS_MSG: next_st.prdata = {12'h000, st.msg_id, st.msg_data};
        default: begin
          if (code_hit) begin
            next_st.prdata = {20'h0_0000, mem_bus.rd_data_a};
          end else begin
            next_st.pslverr = 1'b1;
          end
        end
      endcase
    end
    if (apb_done && pwrite) begin
      case (paddr)
        OFS_CTRL: next_st.ctrl = pwdata[7:0];
        OFS_CFG2: next_st.cfg2 = pwdata[15:0];
        OFS_CONTROL_WORD_ONE: next_st.control_word_one = pwdata[15:0];
        OFS_UPPER: next_st.upper = pwdata[11:0];
        OFS_LOWER: next_st.lower = pwdata[11:0];
        default: next_st.ctrl = st.ctrl;
      endcase
    end

    next_st.prewarn = st.ctrl[CTRL_PW_EN_BIT] &&
      (cond_high || cond_low || cond_uv || cond_ov || cond_temp || cond_sbe);

    case (st.state)
      SSM_IDLE: begin
        next_st.bit2 = 1'b0;
        next_st.bit3 = 1'b0;
        if (st.ctrl[CTRL_ESP_BIT]) begin
          // Start from the slot before the first so the first capture is slot one.
          next_st.slot = SLOT_LAST;
          next_st.frame_cnt = FRAME_LAST;
          next_st.state = SSM_RUN;
        end
      end
      SSM_RUN: begin
        if (frame_start) begin
          {next_st.bit3, next_st.bit2} = frame_bits(st.frame_cnt, st.msg_id, st.msg_data, serial_crc);
          if (st.frame_cnt == FRAME_LAST) begin
            // The next message is latched one frame ahead so its CRC is ready for frame 1.
            next_st.frame_cnt = 5'h00;
            next_st.slot = slot_next;
            next_st.msg_id = slot_id(slot_next);
            next_st.msg_data = slot_data;
            if (!st.ctrl[CTRL_ESP_BIT]) begin
              next_st.state = SSM_IDLE;
              next_st.msg_id = 8'h00;
              next_st.msg_data = 12'h000;
            end
          end else begin
            next_st.frame_cnt = st.frame_cnt + 5'h01;
          end
        end
        // The first message leaves at once without a frame of its own to wait for.
        if (st.frame_cnt == FRAME_LAST && st.msg_id == 8'h00 && st.ctrl[CTRL_ESP_BIT] && !frame_start) begin
          next_st.frame_cnt = 5'h00;
          next_st.slot = slot_next;
          next_st.msg_id = slot_id(slot_next);
          next_st.msg_data = slot_data;
        end
      end
      default: next_st.state = SSM_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{state: SSM_IDLE, slot: 5'h00, frame_cnt: 5'h00, msg_id: 8'h00, msg_data: 12'h000,
              bit2: 1'b0, bit3: 1'b0, prewarn: 1'b0, ctrl: CTRL_RST, cfg2: CFG2_RST, control_word_one: CONTROL_WORD_ONE_RST,
              upper: UPPER_RST, lower: LOWER_RST, pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000};
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign status_bit2 = st.bit2;
  assign status_bit3 = st.bit3;
  assign status_prewarn = st.prewarn;
  assign msg_id = st.msg_id;
  assign msg_data = st.msg_data;
  assign serial_active = st.state == SSM_RUN;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic capture;
  assign capture = st.state == SSM_RUN && frame_start && st.frame_cnt == FRAME_LAST && st.ctrl[CTRL_ESP_BIT];

  a_diag_reserved: assert property (st.msg_id == ID_DIAG |-> !(st.msg_data inside {[12'h003:12'h019]})
    && !(st.msg_data inside {[12'h024:12'h800]})) else $error("reserved diagnostic code sent");
  a_supply_range: assert property (st.msg_id == ID_SUPPLY |-> st.msg_data < SUPPLY_LIMIT)
    else $error("supply code out of range");
  a_mfr_fixed: assert property (st.msg_id == ID_MFR |-> st.msg_data == MFR_CODE)
    else $error("manufacturer code changed");
  a_rev_codes: assert property (st.msg_id == ID_REV |-> st.msg_data inside {12'h000, 12'h002, 12'h003, 12'h004})
    else $error("bad revision code");
  a_type_codes: assert property (capture && slot_next == 5'd3 && st.ctrl[CTRL_TYPE_LSB +: 4] >= 4'hd
    |=> st.msg_data == 12'h000) else $error("reserved type not zero");
  a_msg_hold: assert property (st.state == SSM_RUN && frame_start && st.frame_cnt != FRAME_LAST && st.msg_id != 8'h00
    |=> $stable(st.msg_id) && $stable(st.msg_data)) else $error("message changed mid transmission");
  a_sync_bits: assert property (st.state == SSM_RUN && frame_start && st.frame_cnt < SYNC_FRAMES
    |=> st.bit3 && st.bit2 == $past(serial_crc[3'd5 - st.frame_cnt[2:0]])) else $error("sync frame wrong");
  a_prewarn_set: assert property (st.ctrl[CTRL_PW_EN_BIT] && output_value > st.upper |=> st.prewarn)
    else $error("pre-warning missing");
  a_upper_range_limit: assert property (capture && slot_id(slot_next) == ID_DIAG && !safety_report && cond_high
    |=> st.msg_data == DC_UPPER_RANGE_LIMIT) else $error("upper range code missing");
  a_code_slot: assert property (capture && st.slot == 5'd11 |=> st.msg_id == 8'h92)
    else $error("schedule slot wrong");

  c_wrap: cover property (capture && st.slot == SLOT_LAST);
  c_safety: cover property (st.msg_id == ID_DIAG && st.msg_data > DC_SAFETY_BASE);
  c_code: cover property (st.msg_id == 8'h97 && st.frame_cnt == FRAME_LAST);

endmodule

//--- tb/ssm_rx_model.sv
module ssm_rx_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Frame pacing in clock cycles, three or more.
  input wire logic [3:0] frame_gap,
  // Link from the sensor.
  input wire logic status_bit2,
  input wire logic status_bit3,
  output logic frame_start,
  output logic [5:0] serial_crc,
  // Decoded messages.
  output logic rx_valid,
  output logic [7:0] rx_id,
  output logic [11:0] rx_data,
  output logic [5:0] rx_crc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  logic [17:0] h3;
  logic [17:0] h2;
  logic [17:0] n3;
  logic [17:0] n2;
  assign serial_crc = 6'h2d;
  // Status bits are sampled two edges after the frame pulse is raised, once the sensor has updated them.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      frame_start <= 1'b0;
      h3 <= 18'h0;
      h2 <= 18'h0;
      rx_valid <= 1'b0;
      rx_id <= 8'h00;
      rx_data <= 12'h000;
      rx_crc <= 6'h00;
    end else begin
      frame_start <= (cnt == 4'h0);
      cnt <= (cnt >= frame_gap - 4'h1) ? 4'h0 : cnt + 4'h1;
      rx_valid <= 1'b0;
      if (cnt == 4'h2) begin
        n3 = {h3[16:0], status_bit3};
        n2 = {h2[16:0], status_bit2};
        h2 <= n2;
        // Six leading ones and the fixed zeros mark a whole message; the bit-3 history is cleared to avoid a re-match.
        if (n3[17:12] == 6'h3f && n3[11:10] == 2'h0 && !n3[5] && !n3[0]) begin
          rx_valid <= 1'b1;
          rx_id <= {n3[9:6], n3[4:1]};
          rx_data <= n2[11:0];
          rx_crc <= n2[17:12];
          h3 <= 18'h0;
        end else begin
          h3 <= n3;
        end
      end
    end
  end
endmodule

//--- tb/tb.sv
module tb
  import ssm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary manufacturer value for this bench.
  localparam logic [11:0] MFR = 12'h3c7;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sensor_id_sel, frame_start;
  logic status_bit2, status_bit3, status_prewarn, serial_active, rx_valid;
  logic [7:0] paddr, chip_temp, msg_id, rx_id, ctrl;
  logic [31:0] pwdata, prdata;
  logic [11:0] output_value, msg_data, rx_data, upper, lower;
  logic [8:0] supply_code;
  logic [3:0] undervolt_flags, overvolt_flags, frame_gap;
  logic [10:0] safety_fail;
  logic [5:0] serial_crc, rx_crc;
  logic [15:0] cfg2, control_word_one;
  logic [11:0] code [8];
  logic [7:0] sched [18] = '{8'h01, 8'h23, 8'h1c, 8'h03, 8'h29, 8'h05, 8'h06, 8'h01, 8'h23, 8'h1c,
    8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97};
  logic [11:0] typ_code [16] = '{12'h051, 12'h052, 12'h053, 12'h054, 12'h055, 12'h056, 12'h059, 12'h05a,
    12'h062, 12'h063, 12'h064, 12'h066, 12'h000, 12'h000, 12'h000, 12'h000};
  logic [11:0] rev_code [4] = '{12'h000, 12'h002, 12'h003, 12'h004};
  int n_mismatch, tests_run, seed, slot;
  logic [7:0] ra [7] = '{OFS_CTRL, OFS_CFG2, OFS_CONTROL_WORD_ONE, OFS_UPPER, OFS_LOWER, OFS_CODE_BASE, OFS_CODE_LAST};
  logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h0, 32'hfff, 32'h0, 32'h0, 32'h0};

  ssm_top #(.MFR_CODE(MFR)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .output_value(output_value), .supply_code(supply_code), .undervolt_flags(undervolt_flags),
    .overvolt_flags(overvolt_flags), .chip_temp(chip_temp), .sensor_id_sel(sensor_id_sel),
    .safety_fail(safety_fail), .frame_start(frame_start), .serial_crc(serial_crc),
    .status_bit2(status_bit2), .status_bit3(status_bit3), .status_prewarn(status_prewarn),
    .msg_id(msg_id), .msg_data(msg_data), .serial_active(serial_active));
  ssm_rx_model i_rx (.pclk(pclk), .presetn(presetn), .frame_gap(frame_gap), .status_bit2(status_bit2),
    .status_bit3(status_bit3), .frame_start(frame_start), .serial_crc(serial_crc), .rx_valid(rx_valid),
    .rx_id(rx_id), .rx_data(rx_data), .rx_crc(rx_crc));

  always #5 pclk = ~pclk;

  task automatic give_verdict();
    $display("Counts: %0d comparisons, %0d mismatches", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic err);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      chk("apb ready", 1, 0);
      give_verdict();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk("write error", 0, e);
  endtask

  task automatic get_msg(output logic [7:0] id, output logic [11:0] d);
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (rx_valid !== 1'b1 && k < 2000);
    if (k >= 2000) begin
      chk("message wait", 1, 0);
      give_verdict();
    end
    id = rx_id;
    d = rx_data;
    chk("crc", 6'h2d, rx_crc);
  endtask

  function automatic logic [11:0] exp_diag();
    if (control_word_one[14] && safety_fail != 11'h000) return {1'b1, safety_fail};
    if (output_value > upper) return 12'h001;
    if (output_value < lower) return 12'h002;
    if (undervolt_flags[cfg2[13:12]]) return 12'h020;
    if (overvolt_flags[cfg2[15:14]]) return 12'h021;
    if (chip_temp[7:3] > cfg2[11:7]) return 12'h022;
    if (control_word_one[10]) return 12'h023;
    return 12'h000;
  endfunction

  function automatic logic [11:0] exp_data(input int s);
    case (sched[s])
      8'h01: return exp_diag();
      8'h23: return {4'h0, chip_temp};
      8'h1c: return {3'h0, supply_code};
      8'h03: return typ_code[ctrl[5:2]];
      8'h29: return sensor_id_sel ? 12'hfff : 12'h000;
      8'h05: return MFR;
      8'h06: return rev_code[ctrl[7:6]];
      default: return code[sched[s][2:0]];
    endcase
  endfunction

  initial begin
    logic [31:0] q, r;
    logic e;
    logic [7:0] id;
    logic [11:0] d, ov;
    logic [3:0] uf, of, ty;
    logic [10:0] sf;
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, sensor_id_sel} = '0;
    {output_value, supply_code, undervolt_flags, overvolt_flags, chip_temp, safety_fail} = '0;
    frame_gap = 4'h6;
    seed = 32'h4d27afea;
    slot = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ra[i], 32'h0, q, e);
      chk("reset value", rv[i], q);
    end
    apb(1'b0, 8'h1c, 32'h0, q, e);
    chk("unmapped error", 1, e);
    chk("unmapped data", 0, q);
    for (int i = 0; i < 8; i++) begin
      code[i] = 12'($random(seed));
      wr(OFS_CODE_BASE + 8'(4 * i), {20'h0, code[i]});
      apb(1'b0, OFS_CODE_BASE + 8'(4 * i), 32'h0, q, e);
      chk("customer code", {20'h0, code[i]}, q);
    end
    $display("test registers done");
    for (int it = 0; it < 16; it++) begin
      r = $random(seed);
      ty = 4'(it);
      ctrl = {(ty < 8) ? 2'b10 : (ty < 12) ? 2'b11 : ty[1:0], ty, ty[1], 1'b1};
      cfg2 = 16'($random(seed));
      if (cfg2[11:7] == 5'h1f) cfg2[11:7] = 5'h1e;
      control_word_one = {1'b0, r[13], 14'h0};
      upper = 12'hc00;
      lower = 12'h100;
      ov = {2'b01, r[9:0]};
      uf = ~(4'h1 << cfg2[13:12]);
      of = ~(4'h1 << cfg2[15:14]);
      sf = r[13] ? 11'h000 : r[31:21];
      case (it % 8)
        1: ov = 12'hc01;
        2: ov = 12'h0ff;
        3: uf = ~uf;
        4: of = ~of;
        5: control_word_one[10] = 1'b1;
        6: begin
          control_word_one[14] = 1'b1;
          sf = r[31:21] | (11'h1 << (it % 11));
        end
        default: ;
      endcase
      @(posedge pclk);
      output_value <= ov;
      undervolt_flags <= uf;
      overvolt_flags <= of;
      safety_fail <= sf;
      chip_temp <= {cfg2[11:7] + 5'(it == 7), r[12:10]};
      supply_code <= (it == 15) ? 9'h1ff : r[22:14];
      sensor_id_sel <= r[23];
      frame_gap <= 4'(3 + it % 6);
      wr(OFS_CTRL, {24'h0, ctrl});
      wr(OFS_CFG2, {16'h0, cfg2});
      wr(OFS_CONTROL_WORD_ONE, {16'h0, control_word_one});
      wr(OFS_UPPER, {20'h0, upper});
      wr(OFS_LOWER, {20'h0, lower});
      // The first two messages may still carry data latched before the new settings.
      for (int k = 0; k < 20; k++) begin
        get_msg(id, d);
        chk("message id", sched[slot], id);
        if (k >= 2) chk("message data", exp_data(slot), d);
        if (k >= 2 && id == 8'h01) chk("diag range", 1, d < 12'h003 || (d > 12'h019 && d < 12'h024) || d > 12'h800);
        if (id == 8'h1c) chk("supply range", 1, d < 12'h200);
        slot = (slot + 1) % 18;
      end
      chk("prewarn", ctrl[1] & (ov > upper | ov < lower | uf[cfg2[13:12]] | of[cfg2[15:14]] | it == 7 | control_word_one[10]),
        status_prewarn);
      apb(1'b0, OFS_STATUS, 32'h0, q, e);
      chk("running", 1, q[0]);
      $display("test %0d done", it);
    end
    wr(OFS_CTRL, 32'h0);
    for (int k = 0; k < 500 && serial_active !== 1'b0; k++) @(posedge pclk);
    chk("idle active", 0, serial_active);
    chk("idle id", 0, msg_id);
    chk("idle data", 0, msg_data);
    apb(1'b0, OFS_MSG, 32'h0, q, e);
    chk("idle message register", 0, q);
    $display("test disable done");
    give_verdict();
  end
endmodule
